// [src/cca_pkg.sv]
// Purpose: constants, types and state records of the counter array
// Assumes: byte wide register port, one clock
// Notes: offsets are register indexes on the local register port
package cca_pkg;
  // ***********************************************
  // register indexes
  // ***********************************************
  localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
  localparam logic [7:0] OFS_COUNT_HIGH = 8'h01;
  localparam logic [7:0] OFS_ARRAY_MODE = 8'h02;
  localparam logic [7:0] OFS_ARRAY_CTRL = 8'h03;
  localparam logic [7:0] OFS_LINE_STATE = 8'h04;
  localparam logic [7:0] OFS_MODE_BASE = 8'h08;
  localparam logic [7:0] OFS_CAPL_BASE = 8'h10;
  localparam logic [7:0] OFS_CAPH_BASE = 8'h18;
  // ***********************************************
  // fields
  // ***********************************************
  localparam int MD_IDLE = 7;
  localparam int MD_WDT = 6;
  localparam int MD_TB_LSB = 1;
  localparam int MD_OVF_IE = 0;
  localparam int CN_OVF = 7;
  localparam int CN_RUN = 6;
  localparam int MM_PWM16 = 7;
  localparam int MM_ECOM = 6;
  localparam int MM_CAPP = 5;
  localparam int MM_CAPN = 4;
  localparam int MM_MAT = 3;
  localparam int MM_TOG = 2;
  localparam int MM_PWM = 1;
  localparam int MM_ECCF = 0;
  localparam logic [7:0] MD_WRITE_MASK = 8'hcf;
  localparam logic [7:0] MD_FROZEN_MASK = 8'h8e;
  localparam logic [7:0] CN_WRITE_MASK = 8'hdf;
  // ***********************************************
  // reset values
  // ***********************************************
  localparam logic [7:0] ARRAY_MODE_RST = 8'h40;
  localparam logic [7:0] ARRAY_CTRL_RST = 8'h00;
  localparam logic [7:0] MODULE_MODE_RST = 8'h00;
  localparam logic [15:0] CAPTURE_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] WDT_MODULE_MODE = 8'h48;
  localparam int NUM_MODULES = 5;
  localparam int WDT_MODULE = 4;
  // ***********************************************
  // timebase
  // ***********************************************
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_T0 = 3'h2;
  localparam logic [2:0] TB_ECI = 3'h3;
  localparam logic [2:0] TB_SYS = 3'h4;
  localparam logic [2:0] TB_OSC8 = 3'h5;
  localparam logic [3:0] DIV_SLOW = 4'hc;
  localparam logic [3:0] DIV_FAST = 4'h4;
  localparam logic [3:0] DIV_OSC = 4'h8;

  typedef enum logic [6:0] {
    CM_OFF = 7'h01,
    CM_CAPTURE = 7'h02,
    CM_SWTIMER = 7'h04,
    CM_HSO = 7'h08,
    CM_FREQ = 7'h10,
    CM_PWM8 = 7'h20,
    CM_PWM16 = 7'h40
  } cca_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } cca_sfr_req_s;

  typedef struct packed {
    logic tick;
    logic ovf_low;
    logic ovf16;
    logic [15:0] count;
  } cca_count_s;

  typedef struct packed {
    logic [3:0] pre;
    logic eci1, eci2, eci3;
    logic osc1, osc2, osc3;
  } cca_tb_s;

  typedef struct packed {
    logic s1, s2, s3;
    logic [15:0] cap;
    logic out;
    logic eq16_d;
    logic eq8_d;
  } cca_ccm_s;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0] snap;
    logic [7:0] md;
    logic [7:0] cn;
    logic [NUM_MODULES-1:0][7:0] mm;
    logic [7:0] rdata;
  } cca_top_s;
endpackage

// [src/cca_timebase.sv]
// Purpose: counter clock source selection
// Assumes: all inputs synchronous except the oscillator and the external count input
// Notes: tick is a one cycle advance request
`timescale 1ns/100ps
module cca_timebase (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [2:0] sel,
  input wire logic timer0_ovf,
  input wire logic ext_count_input,
  input wire logic ext_osc_in,
  output logic tick
);
  cca_pkg::cca_tb_s st, nx;
  logic [3:0] lim;
  logic step, wrap, eci_fall, osc_rise;

  always_comb begin
    nx = st;
    nx.eci1 = ext_count_input;
    nx.eci2 = st.eci1;
    nx.eci3 = st.eci2;
    nx.osc1 = ext_osc_in;
    nx.osc2 = st.osc1;
    nx.osc3 = st.osc2;
    eci_fall = st.eci3 & ~st.eci2;
    // oscillator counted only after two-flop resync
    osc_rise = st.osc2 & ~st.osc3;
    lim = (sel == cca_pkg::TB_DIV4) ? cca_pkg::DIV_FAST :
          (sel == cca_pkg::TB_OSC8) ? cca_pkg::DIV_OSC : cca_pkg::DIV_SLOW;
    step = (sel == cca_pkg::TB_OSC8) ? osc_rise : 1'b1;
    // >= keeps a select change from running past the limit
    wrap = step && (st.pre >= lim - 4'h1);
    nx.pre = wrap ? 4'h0 : st.pre + {3'h0, step};
    case (sel)
      cca_pkg::TB_DIV12, cca_pkg::TB_DIV4, cca_pkg::TB_OSC8: tick = wrap;
      cca_pkg::TB_T0: tick = timer0_ovf;
      cca_pkg::TB_ECI: tick = eci_fall;
      cca_pkg::TB_SYS: tick = 1'b1;
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= nx;
    end
  end

  div12_space_a: assert property (@(posedge sys_clk) disable iff (!rst_n || !ce)
    tick && sel == cca_pkg::TB_DIV12 |=> (!tick || sel != cca_pkg::TB_DIV12)[*8])
    else $error("divide by 12 ticks too close");
endmodule

// [src/cca_ccm.sv]
// Purpose: one capture/compare module
// Assumes: count record from the array counter
// Notes: comparator matches are taken on the rising edge of equality
`timescale 1ns/100ps
module cca_ccm (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] mode,
  input wire cca_pkg::cca_count_s cnt,
  input wire logic cap_low_wr,
  input wire logic cap_high_wr,
  input wire logic [7:0] wdata,
  input wire logic line_in,
  output logic [15:0] cap_val,
  output logic event_pulse,
  output logic line_out,
  output logic line_oe,
  output logic line_level
);
  cca_pkg::cca_ccm_s st, nx;
  cca_pkg::cca_mode_e md;
  logic rise, fall, ecom, eq16, eq8, m16, m8;

  // ***********************************************
  // mode decode
  // ***********************************************
  always_comb begin
    md = cca_pkg::CM_OFF;
    if ((mode[cca_pkg::MM_CAPP] | mode[cca_pkg::MM_CAPN]) && mode[3:1] == 3'h0) begin
      md = cca_pkg::CM_CAPTURE;
    end else if (mode[5:4] == 2'h0 && mode[3:1] == 3'h4) begin
      md = cca_pkg::CM_SWTIMER;
    end else if (mode[5:4] == 2'h0 && mode[3:1] == 3'h6) begin
      md = cca_pkg::CM_HSO;
    end else if (mode[5:4] == 2'h0 && mode[3:1] == 3'h3) begin
      md = cca_pkg::CM_FREQ;
    end else if (mode[5:4] == 2'h0 && mode[2:1] == 2'h1) begin
      md = mode[cca_pkg::MM_PWM16] ? cca_pkg::CM_PWM16 : cca_pkg::CM_PWM8;
    end
  end

  // ***********************************************
  // capture and compare
  // ***********************************************
  always_comb begin
    nx = st;
    event_pulse = 1'b0;
    // first flop feeds only the second
    nx.s1 = line_in;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    rise = st.s2 & ~st.s3;
    fall = ~st.s2 & st.s3;
    ecom = mode[cca_pkg::MM_ECOM];
    eq16 = ecom && cnt.count == st.cap;
    eq8 = ecom && cnt.count[7:0] == st.cap[7:0];
    m16 = eq16 & ~st.eq16_d;
    m8 = eq8 & ~st.eq8_d;
    nx.eq16_d = eq16;
    nx.eq8_d = eq8;
    case (md)
      cca_pkg::CM_CAPTURE: begin
        if ((rise & mode[cca_pkg::MM_CAPP]) | (fall & mode[cca_pkg::MM_CAPN])) begin
          nx.cap = cnt.count;
          event_pulse = 1'b1;
        end
      end
      cca_pkg::CM_SWTIMER: event_pulse = m16;
      cca_pkg::CM_HSO: begin
        event_pulse = m16;
        if (m16) begin
          nx.out = ~st.out;
        end
      end
      cca_pkg::CM_FREQ: begin
        event_pulse = m16 & mode[cca_pkg::MM_MAT];
        if (m8) begin
          nx.out = ~st.out;
          nx.cap[7:0] = st.cap[7:0] + st.cap[15:8];
        end
      end
      cca_pkg::CM_PWM8: begin
        event_pulse = m8 & mode[cca_pkg::MM_MAT];
        if (!ecom || cnt.ovf_low) begin
          nx.out = 1'b0;
        end else if (m8) begin
          nx.out = 1'b1;
        end
        if (cnt.ovf_low) begin
          nx.cap[7:0] = st.cap[15:8];
        end
      end
      cca_pkg::CM_PWM16: begin
        event_pulse = m16 & mode[cca_pkg::MM_MAT];
        if (!ecom || cnt.ovf16) begin
          nx.out = 1'b0;
        end else if (m16) begin
          nx.out = 1'b1;
        end
      end
      default: ;
    endcase
    // software writes take priority over hardware updates
    if (cap_low_wr) begin
      nx.cap[7:0] = wdata;
    end
    if (cap_high_wr) begin
      nx.cap[15:8] = wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else if (ce) begin
      st <= nx;
    end
  end

  assign cap_val = st.cap;
  assign line_out = st.out;
  assign line_oe = (md == cca_pkg::CM_HSO) || (md == cca_pkg::CM_FREQ) ||
                   (md == cca_pkg::CM_PWM8) || (md == cca_pkg::CM_PWM16);
  assign line_level = st.s2;

  cap_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && md == cca_pkg::CM_CAPTURE && event_pulse && !cap_low_wr && !cap_high_wr
    |=> cap_val == $past(cnt.count)) else $error("capture did not load the count");
  pwm_off_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ce && (md == cca_pkg::CM_PWM8 || md == cca_pkg::CM_PWM16) && !ecom |=> !line_out)
    else $error("pwm drives high with comparator off");
endmodule

// [src/cca_top.sv]
// Purpose: counter array with five capture/compare modules
// Assumes: register port strobes are single cycle, read data next cycle
// Notes: module 4 comes out of reset in watchdog mode
`timescale 1ns/100ps
module cca_top (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire cca_pkg::cca_sfr_req_s sfr_req,
  output logic [7:0] sfr_rdata,
  input wire logic cpu_idle,
  input wire logic timer0_ovf,
  input wire logic ext_count_input,
  input wire logic ext_osc_in,
  input wire logic [cca_pkg::NUM_MODULES-1:0] module_line_in,
  output logic [cca_pkg::NUM_MODULES-1:0] module_line_out,
  output logic [cca_pkg::NUM_MODULES-1:0] module_line_oe,
  output logic irq_req
);
  localparam int N = cca_pkg::NUM_MODULES;
  cca_pkg::cca_top_s st, nx;
  cca_pkg::cca_count_s cnt;
  logic [1:0] rst_sync;
  logic rs_n, tb_tick, wdt, adv;
  logic [N-1:0] ev, line_level, cap_low_wr, cap_high_wr;
  logic [N-1:0][7:0] eff_mode;
  logic [N-1:0][15:0] cap_val;

  // ***********************************************
  // reset release
  // ***********************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rs_n = rst_sync[1];

  // ***********************************************
  // timebase and modules
  // ***********************************************
  cca_timebase u_tb (
    .sys_clk(sys_clk),
    .rst_n(rs_n),
    .ce(ce),
    .sel(st.md[cca_pkg::MD_TB_LSB +: 3]),
    .timer0_ovf(timer0_ovf),
    .ext_count_input(ext_count_input),
    .ext_osc_in(ext_osc_in),
    .tick(tb_tick)
  );

  assign wdt = st.md[cca_pkg::MD_WDT];
  // idle only halts the count when suspend is set, and
  assign adv = tb_tick && (st.cn[cca_pkg::CN_RUN] || wdt) && !(st.md[cca_pkg::MD_IDLE] && cpu_idle);
  assign cnt.tick = adv;
  assign cnt.count = st.count;
  assign cnt.ovf_low = adv && st.count[7:0] == 8'hff;
  assign cnt.ovf16 = adv && st.count == 16'hffff;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_mod
      // watchdog forces module 4 into software timer mode
      assign eff_mode[g] = (wdt && g == cca_pkg::WDT_MODULE) ? cca_pkg::WDT_MODULE_MODE : st.mm[g];
      assign cap_low_wr[g] = sfr_req.wr && sfr_req.addr == cca_pkg::OFS_CAPL_BASE + 8'(g);
      assign cap_high_wr[g] = sfr_req.wr && sfr_req.addr == cca_pkg::OFS_CAPH_BASE + 8'(g);
      cca_ccm u_ccm (
        .sys_clk(sys_clk),
        .rst_n(rs_n),
        .ce(ce),
        .mode(eff_mode[g]),
        .cnt(cnt),
        .cap_low_wr(cap_low_wr[g]),
        .cap_high_wr(cap_high_wr[g]),
        .wdata(sfr_req.wdata),
        .line_in(module_line_in[g]),
        .cap_val(cap_val[g]),
        .event_pulse(ev[g]),
        .line_out(module_line_out[g]),
        .line_oe(module_line_oe[g]),
        .line_level(line_level[g])
      );
    end
  endgenerate

  // ***********************************************
  // registers
  // ***********************************************
  always_comb begin
    nx = st;
    if (adv) begin
      nx.count = st.count + 16'h0001;
    end
    if (sfr_req.rd) begin
      // reads change only the read data and, on a low byte read, the snapshot
      if (sfr_req.addr == cca_pkg::OFS_COUNT_LOW) begin
        nx.rdata = st.count[7:0];
        nx.snap = st.count[15:8];
      end else if (sfr_req.addr == cca_pkg::OFS_COUNT_HIGH) begin
        nx.rdata = st.snap;
      end else if (sfr_req.addr == cca_pkg::OFS_ARRAY_MODE) begin
        nx.rdata = st.md;
      end else if (sfr_req.addr == cca_pkg::OFS_ARRAY_CTRL) begin
        nx.rdata = st.cn;
      end else if (sfr_req.addr == cca_pkg::OFS_LINE_STATE) begin
        nx.rdata = {3'h0, line_level};
      end else begin
        nx.rdata = 8'h00;
        for (int i = 0; i < N; i++) begin
          if (sfr_req.addr == cca_pkg::OFS_MODE_BASE + 8'(i)) begin
            nx.rdata = eff_mode[i];
          end else if (sfr_req.addr == cca_pkg::OFS_CAPL_BASE + 8'(i)) begin
            nx.rdata = cap_val[i][7:0];
          end else if (sfr_req.addr == cca_pkg::OFS_CAPH_BASE + 8'(i)) begin
            nx.rdata = cap_val[i][15:8];
          end
        end
      end
    end
    if (sfr_req.wr) begin
      // counter, timebase, idle and module 4 mode locked by watchdog
      if (sfr_req.addr == cca_pkg::OFS_COUNT_LOW) begin
        if (!wdt) begin
          nx.count[7:0] = sfr_req.wdata;
        end
      end else if (sfr_req.addr == cca_pkg::OFS_COUNT_HIGH) begin
        if (!wdt) begin
          nx.count[15:8] = sfr_req.wdata;
        end
      end else if (sfr_req.addr == cca_pkg::OFS_ARRAY_MODE) begin
        nx.md = sfr_req.wdata & cca_pkg::MD_WRITE_MASK;
        if (wdt) begin
          nx.md = (nx.md & ~cca_pkg::MD_FROZEN_MASK) | (st.md & cca_pkg::MD_FROZEN_MASK);
        end
      end else if (sfr_req.addr == cca_pkg::OFS_ARRAY_CTRL) begin
        nx.cn = sfr_req.wdata & cca_pkg::CN_WRITE_MASK;
      end else begin
        for (int i = 0; i < N; i++) begin
          if (sfr_req.addr == cca_pkg::OFS_MODE_BASE + 8'(i) && !(wdt && i == cca_pkg::WDT_MODULE)) begin
            nx.mm[i] = sfr_req.wdata;
          end else if (cap_low_wr[i]) begin
            nx.mm[i][cca_pkg::MM_ECOM] = 1'b0;
          end else if (cap_high_wr[i]) begin
            nx.mm[i][cca_pkg::MM_ECOM] = 1'b1;
          end
        end
      end
    end
    // hardware sets win over a clearing write, and
    if (cnt.ovf16) begin
      nx.cn[cca_pkg::CN_OVF] = 1'b1;
    end
    for (int i = 0; i < N; i++) begin
      if (ev[i]) begin
        nx.cn[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rs_n) begin
    if (!rs_n) begin
      st.count <= cca_pkg::COUNT_RST;
      st.snap <= 8'h00;
      st.md <= cca_pkg::ARRAY_MODE_RST;
      st.cn <= cca_pkg::ARRAY_CTRL_RST;
      st.mm <= {N{cca_pkg::MODULE_MODE_RST}};
      st.rdata <= 8'h00;
    end else if (ce) begin
      st <= nx;
    end
  end

  assign sfr_rdata = st.rdata;

  // interrupt is the OR of enabled flags
  always_comb begin
    irq_req = st.cn[cca_pkg::CN_OVF] & st.md[cca_pkg::MD_OVF_IE];
    for (int i = 0; i < N; i++) begin
      irq_req = irq_req | (st.cn[i] & eff_mode[i][cca_pkg::MM_ECCF]);
    end
  end

  // ***********************************************
  // checks
  // ***********************************************
  snap_copy_a: assert property (@(posedge sys_clk) disable iff (!rs_n)
    ce && sfr_req.rd && sfr_req.addr == cca_pkg::OFS_COUNT_LOW ##1 ce && sfr_req.rd
    && sfr_req.addr == cca_pkg::OFS_COUNT_HIGH |=> sfr_rdata == $past(st.count[15:8], 2))
    else $error("high byte read missed the snapshot");
  read_no_disturb_a: assert property (@(posedge sys_clk) disable iff (!rs_n)
    ce && sfr_req.rd && !sfr_req.wr && adv |=> st.count == $past(st.count) + 16'h0001)
    else $error("counter disturbed by a read");
  ovf_set_a: assert property (@(posedge sys_clk) disable iff (!rs_n)
    ce && st.count == 16'hffff && adv |=> st.cn[cca_pkg::CN_OVF] && st.count == 16'h0000)
    else $error("wrap did not set overflow");
  ovf_irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rs_n)
    !st.md[cca_pkg::MD_OVF_IE] && st.cn[4:0] == 5'h00 |-> !irq_req)
    else $error("interrupt without an enabled flag");
  flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rs_n)
    st.cn[cca_pkg::CN_OVF] && !(sfr_req.wr && sfr_req.addr == cca_pkg::OFS_ARRAY_CTRL)
    |=> st.cn[cca_pkg::CN_OVF]) else $error("overflow flag cleared by hardware");
  idle_hold_a: assert property (@(posedge sys_clk) disable iff (!rs_n)
    ce && cpu_idle && st.md[cca_pkg::MD_IDLE] && !sfr_req.wr |=> $stable(st.count))
    else $error("counter advanced in suspended idle");
  wdt_freeze_a: assert property (@(posedge sys_clk) disable iff (!rs_n)
    wdt |=> st.md[3:1] == $past(st.md[3:1]) && st.md[cca_pkg::MD_IDLE] == $past(st.md[cca_pkg::MD_IDLE]))
    else $error("watchdog did not freeze the timebase");
endmodule

// [test/cca_core_model.sv]
// Purpose: processor core side of the counter array register port
// Assumes: requests launched at the falling edge, one strobe cycle each
// Notes: idle address and data are inverted so stale values never match
`timescale 1ns/100ps
module cca_core_model (
  input wire logic sys_clk,
  input wire logic irq_req,
  input wire logic global_irq_enable,
  input wire logic array_irq_enable,
  input wire logic [7:0] sfr_rdata,
  output cca_pkg::cca_sfr_req_s sfr_req,
  output logic irq_taken
);
  // core sees the request only with both enables set
  assign irq_taken = irq_req & global_irq_enable & array_irq_enable;
  initial sfr_req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge sys_clk);
    sfr_req = '{addr: a, wr: w, rd: !w, wdata: d};
    @(negedge sys_clk);
    sfr_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    @(negedge sys_clk);
    q = sfr_rdata;
  endtask
endmodule

// [test/testbench.sv]
// Purpose: self-checking bench of the counter array
// Assumes: core model drives the register port
// Notes: counter is frozen by idle suspend where exact values are needed
`timescale 1ns/100ps
module testbench;
  localparam logic [7:0] LOW = cca_pkg::OFS_COUNT_LOW;
  localparam logic [7:0] HIGH = cca_pkg::OFS_COUNT_HIGH;
  localparam logic [7:0] MODE = cca_pkg::OFS_ARRAY_MODE;
  localparam logic [7:0] CTRL = cca_pkg::OFS_ARRAY_CTRL;
  localparam logic [7:0] MM = cca_pkg::OFS_MODE_BASE;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_idle = 1'b0;
  logic timer0_ovf = 1'b0;
  logic ext_count_input = 1'b1;
  logic ext_osc_in = 1'b0;
  logic [4:0] line_in = 5'h00;
  logic [4:0] line_out;
  logic [4:0] line_oe;
  logic [7:0] rdata;
  logic [7:0] q0;
  logic [7:0] q1;
  logic irq_req;
  cca_pkg::cca_sfr_req_s req;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int p10[6] = '{120, 40, 100, 160, 10, 234};
  always #2.5 sys_clk = ~sys_clk;
  // oscillator unrelated in phase to the system clock
  always #7.3 ext_osc_in = ~ext_osc_in;
  always @(negedge sys_clk) begin
    cyc <= cyc + 1;
    timer0_ovf <= (cyc % 10 == 0);
    ext_count_input <= (cyc % 16 < 8);
  end
  cca_top uut (.sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .sfr_req(req), .sfr_rdata(rdata),
    .cpu_idle(cpu_idle), .timer0_ovf(timer0_ovf), .ext_count_input(ext_count_input),
    .ext_osc_in(ext_osc_in), .module_line_in(line_in), .module_line_out(line_out),
    .module_line_oe(line_oe), .irq_req(irq_req));
  cca_core_model core (.sys_clk(sys_clk), .irq_req(irq_req), .global_irq_enable(1'b1),
    .array_irq_enable(1'b1), .sfr_rdata(rdata), .sfr_req(req), .irq_taken());
  // ***********************************************
  // helpers
  // ***********************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    core.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    core.xfer(1'b0, a, 8'h00, q);
  endtask
  // reads 96 cycles apart; one count of slack for edge phase
  task automatic measure(input int e);
    logic [7:0] d;
    rd(LOW, q0);
    repeat (93) @(negedge sys_clk);
    rd(LOW, q1);
    d = q1 - q0;
    tests_run++;
    if ($isunknown(d) || d > e + 1 || d + 1 < e) begin
      miscompares++;
      $display("CHECK FAILED count advance expected %0d seen %0d", e, d);
    end
  endtask
  task automatic watch3(output int hi, output int oe_lo);
    hi = 0;
    oe_lo = 0;
    repeat (260) begin
      @(negedge sys_clk);
      if (line_out[3] !== 1'b0) hi++;
      if (line_oe[3] !== 1'b1) oe_lo++;
    end
  endtask
  // ***********************************************
  // scenarios
  // ***********************************************
  task automatic t_reset;
    rd(MODE, q1);
    check("array mode", 8'h40, q1);
    wr(MM + 8'h04, 8'h00);
    rd(MM + 8'h04, q1);
    check("module 4 mode", 8'h48, q1);
    rd(CTRL, q1);
    // forced module 4 matches the zero count right after reset
    check("control", 8'h10, q1);
    wr(MODE, 8'h00);
    wr(CTRL, 8'h40);
    rd(MODE, q1);
    check("array mode off", 8'h00, q1);
    $display("test reset done");
  endtask
  task automatic t_timebase;
    for (int i = 0; i < 6; i++) begin
      wr(MODE, {4'h0, 3'(i), 1'b0});
      measure(960 / p10[i]);
    end
    $display("test timebase done");
  endtask
  task automatic t_idle;
    cpu_idle = 1'b1;
    wr(MODE, 8'h08);
    measure(96);
    wr(MODE, 8'h88);
    measure(0);
    $display("test idle done");
  endtask
  task automatic t_snapshot;
    wr(LOW, 8'hff);
    wr(HIGH, 8'h12);
    rd(LOW, q1);
    check("count low", 8'hff, q1);
    cpu_idle = 1'b0;
    repeat (10) @(negedge sys_clk);
    rd(HIGH, q1);
    check("snapshot", 8'h12, q1);
    rd(LOW, q1);
    rd(HIGH, q1);
    check("count high", 8'h13, q1);
    $display("test snapshot done");
  endtask
  task automatic t_overflow;
    cpu_idle = 1'b1;
    wr(LOW, 8'hf0);
    wr(HIGH, 8'hff);
    cpu_idle = 1'b0;
    repeat (30) @(negedge sys_clk);
    rd(CTRL, q1);
    check("overflow flag", 8'hc0, q1);
    check("irq masked", 8'h00, {7'h0, irq_req});
    wr(MODE, 8'h89);
    check("irq enabled", 8'h01, {7'h0, irq_req});
    repeat (20) @(negedge sys_clk);
    rd(CTRL, q1);
    check("flag kept", 8'hc0, q1);
    wr(CTRL, 8'h40);
    rd(CTRL, q1);
    check("flag cleared", 8'h40, q1);
    check("irq cleared", 8'h00, {7'h0, irq_req});
    $display("test overflow done");
  endtask
  task automatic t_capture;
    cpu_idle = 1'b1;
    wr(MODE, 8'h88);
    wr(LOW, 8'h34);
    wr(HIGH, 8'h12);
    wr(MM, 8'h21);
    wr(MM + 8'h01, 8'h10);
    wr(MM + 8'h02, 8'h30);
    line_in = 5'h07;
    repeat (8) @(negedge sys_clk);
    rd(CTRL, q1);
    check("rising flags", 8'h45, q1);
    check("module irq", 8'h01, {7'h0, irq_req});
    rd(cca_pkg::OFS_LINE_STATE, q1);
    check("line state", 8'h07, q1);
    rd(cca_pkg::OFS_CAPL_BASE, q1);
    check("capture low 0", 8'h34, q1);
    rd(cca_pkg::OFS_CAPH_BASE + 8'h02, q1);
    check("capture high 2", 8'h12, q1);
    line_in = 5'h00;
    repeat (8) @(negedge sys_clk);
    rd(CTRL, q1);
    check("falling flags", 8'h47, q1);
    rd(cca_pkg::OFS_LINE_STATE, q1);
    check("line state low", 8'h00, q1);
    wr(CTRL, 8'h40);
    check("irq after clear", 8'h00, {7'h0, irq_req});
    $display("test capture done");
  endtask
  task automatic t_pwm;
    int hi;
    int oe_lo;
    cpu_idle = 1'b0;
    wr(cca_pkg::OFS_CAPL_BASE + 8'h03, 8'h80);
    wr(cca_pkg::OFS_CAPH_BASE + 8'h03, 8'h80);
    wr(MM + 8'h03, 8'h02);
    watch3(hi, oe_lo);
    check("pwm off high", 8'h00, 8'(hi));
    check("pwm drive", 8'h00, 8'(oe_lo));
    wr(MM + 8'h03, 8'h4a);
    watch3(hi, oe_lo);
    check("pwm on toggles", 8'h01, {7'h0, hi > 0});
    rd(CTRL, q1);
    check("match flag", 8'h08, q1 & 8'h08);
    $display("test pwm done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100us;
    miscompares++;
    $display("watchdog expired before the tests ended");
    results;
  end
  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset;
    t_timebase;
    t_idle;
    t_snapshot;
    t_overflow;
    t_capture;
    t_pwm;
    results;
  end
endmodule
